//--- rtl/spwm_timer.sv
// Single channel PWM timer with shadowed period and compare, APB register slave.
//
// Operation
// - Count clock is prescaled module clock, optional divide by 256, or external input.
// - Counter only counts upward while running.
// - Counter equal to active period flags period match, clears on next tick.
// - A period lasts period value plus one count ticks.
// - Active period loads from shadow period only on shadow transfer.
// - Zero match is active whenever the counter is zero.
// - Single shot bit makes hardware clear run flag at period end.
// - Run flag is set and cleared by write-one set and clear bits.
// - Counter clear bit zeroes the counter only, run flag untouched.
// - Shadow transfer enable flag has write-one set and clear bits.
// - Counter writes ignored while running, applied at once when stopped.
// - Period address writes shadow and reads active value.
// - Selected companion event under selected direction sets the run flag.
// - Event selector: none, ch0, ch1, ch2, any, period, zero up, hall.
// - Direction qualifier: reserved, up only, down only, either.
// - Compare match on counter equal active compare; compare reloads on transfer.
// - Compare event signalled on every match while running, regardless of state bit.
// - Software sets and clears the channel state bit via modify register.
// - Hardware changes state bit only while running.
// - State bit set on tick after compare match, including with zero match.
// - State bit cleared on tick after zero match without compare match.
// - Counter is 16 bits compared for equality with one channel.
// - Set and clear written together leave the flag unchanged.
// - Transfer on next tick when stopped, or period match when enabled; enable self-clears.
`timescale 1ns/100ps
`include "spwm_cfg.svh"

module spwm_timer #(
  parameter int CNT_WIDTH = 16,
  parameter int PRESC_WIDTH = 4
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Companion timer events and external count input.
  input wire spwm_pkg::spwm_companion_type companion,
  input wire logic external_count_input,
  // Timer state.
  output spwm_pkg::spwm_status_type status
);
  import spwm_pkg::*;

  // ----------------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------------
  if (CNT_WIDTH != 16) begin : g_bad_width
    $error("counter width must be 16");
  end
  if (PRESC_WIDTH < 1 || PRESC_WIDTH > 4) begin : g_bad_presc
    $error("prescaler select must be 1 to 4 bits");
  end

  // ----------------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------------
  logic [31:0] ctrl;
  logic run_flag, shadow_xfer_enable, channel_state_bit, ext_prev, tick;
  logic [15:0] pwm_counter, active_period, shadow_period, active_compare, shadow_compare;
  logic [7:0] div256_cnt;

  // ----------------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------------
  logic wr_en, hit;
  assign wr_en = psel && penable && pwrite;
  assign hit = (paddr == `SPWM_OFF_CTRL) || (paddr == `SPWM_OFF_CMD) ||
               (paddr == `SPWM_OFF_COUNT) || (paddr == `SPWM_OFF_PERIOD) ||
               (paddr == `SPWM_OFF_COMPARE) || (paddr == `SPWM_OFF_STATUS) ||
               (paddr == `SPWM_OFF_MODIFY);
  logic wr_cmd, wr_mod;
  assign wr_cmd = wr_en && (paddr == `SPWM_OFF_CMD);
  assign wr_mod = wr_en && (paddr == `SPWM_OFF_MODIFY);

  // Set and clear written together cancel out.
  logic run_set_bit, run_clear_bit, shadow_enable_set_bit, shadow_enable_clear_bit;
  logic state_set_bit, state_clear_bit, counter_clear_bit;
  assign run_set_bit = wr_cmd && pwdata[`SPWM_CMD_RUN_SET] &&
                       !pwdata[`SPWM_CMD_RUN_CLR];
  assign run_clear_bit = wr_cmd && pwdata[`SPWM_CMD_RUN_CLR] &&
                         !pwdata[`SPWM_CMD_RUN_SET];
  assign shadow_enable_set_bit = wr_cmd && pwdata[`SPWM_CMD_SHD_SET] &&
                                 !pwdata[`SPWM_CMD_SHD_CLR];
  assign shadow_enable_clear_bit = wr_cmd && pwdata[`SPWM_CMD_SHD_CLR] &&
                                   !pwdata[`SPWM_CMD_SHD_SET];
  assign state_set_bit = wr_mod && pwdata[`SPWM_MOD_STATE_SET] &&
                         !pwdata[`SPWM_MOD_STATE_CLR];
  assign state_clear_bit = wr_mod && pwdata[`SPWM_MOD_STATE_CLR] &&
                           !pwdata[`SPWM_MOD_STATE_SET];
  assign counter_clear_bit = wr_cmd && pwdata[`SPWM_CMD_CNT_CLR];

  // Zero wait state slave; unmapped addresses answer with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  // Read data is prepared in the setup cycle so it stands registered in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `SPWM_OFF_CTRL: prdata <= ctrl;
        `SPWM_OFF_COUNT: prdata <= {16'h0000, pwm_counter};
        `SPWM_OFF_PERIOD: prdata <= {16'h0000, active_period};
        `SPWM_OFF_COMPARE: prdata <= {16'h0000, active_compare};
        `SPWM_OFF_STATUS: prdata <= {28'h000_0000, status.channel_compare_event,
                                     channel_state_bit, shadow_xfer_enable, run_flag};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register: prescaler, divider, source, single shot and trigger fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SPWM_RST_CTRL;
    end else if (wr_en && paddr == `SPWM_OFF_CTRL) begin
      ctrl <= pwdata & 32'h0000_377F;
    end
  end

  // Shadow registers take software writes at any time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_period <= `SPWM_RST_COUNT;
      shadow_compare <= `SPWM_RST_COUNT;
    end else begin
      if (wr_en && paddr == `SPWM_OFF_PERIOD) begin
        shadow_period <= pwdata[15:0];
      end
      if (wr_en && paddr == `SPWM_OFF_COMPARE) begin
        shadow_compare <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Count clock enable
  // ----------------------------------------------------------------------------
  logic [PRESC_WIDTH-1:0] presc_sel;
  logic presc_tick;
  logic [15:0] presc_top, presc_cnt;
  assign presc_sel = ctrl[`SPWM_CTRL_PRESC_LSB +: PRESC_WIDTH];
  assign presc_top = 16'((32'd1 << presc_sel) - 32'd1);
  assign presc_tick = (presc_cnt >= presc_top);

  // Dividers are held in reset while stopped so that delays are reproducible.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt <= 16'h0000;
      div256_cnt <= 8'h00;
    end else if (!run_flag) begin
      presc_cnt <= 16'h0000;
      div256_cnt <= 8'h00;
    end else if (presc_tick) begin
      presc_cnt <= 16'h0000;
      div256_cnt <= 8'(div256_cnt + 8'h01);
    end else begin
      presc_cnt <= 16'(presc_cnt + 16'h0001);
    end
  end

  // External input counts rising edges; the pin is taken as synchronous.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= external_count_input;
    end
  end

  // One-cycle count tick from the selected source; ticks also run while stopped, except under
  // divide by 256, so that a stopped timer still performs its shadow transfer.
  always_comb begin
    if (ctrl[`SPWM_CTRL_EXTSEL]) begin
      tick = external_count_input && !ext_prev;
    end else if (ctrl[`SPWM_CTRL_DIV256]) begin
      tick = presc_tick && (div256_cnt == 8'hFF);
    end else begin
      tick = presc_tick || !run_flag;
    end
  end

  // ----------------------------------------------------------------------------
  // Matches and shadow transfer
  // ----------------------------------------------------------------------------
  logic period_match, zero_match, compare_match, shadow_xfer_signal;
  assign period_match = (pwm_counter == active_period);
  assign zero_match = (pwm_counter == 16'h0000);
  assign compare_match = (pwm_counter == active_compare);
  assign shadow_xfer_signal = !run_flag || (shadow_xfer_enable && period_match);

  // Active period and compare reload only on a count tick with transfer active.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_period <= `SPWM_RST_COUNT;
      active_compare <= `SPWM_RST_COUNT;
    end else if (tick && shadow_xfer_signal) begin
      active_period <= shadow_period;
      active_compare <= shadow_compare;
    end
  end

  // Enable flag: software set and clear; the transfer clears it, but a set in
  // the same cycle wins so software intent is not lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_xfer_enable <= 1'b0;
    end else if (shadow_enable_set_bit) begin
      shadow_xfer_enable <= 1'b1;
    end else if (shadow_enable_clear_bit || (tick && shadow_xfer_signal)) begin
      shadow_xfer_enable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Hardware start from companion events
  // ----------------------------------------------------------------------------
  logic event_sel, dir_ok, hw_start;
  always_comb begin
    unique case (spwm_tec_type'(ctrl[`SPWM_CTRL_TEC_MSB:`SPWM_CTRL_TEC_LSB]))
      SPWM_TEC_NONE: event_sel = 1'b0;
      SPWM_TEC_CH0: event_sel = companion.ch_compare[0];
      SPWM_TEC_CH1: event_sel = companion.ch_compare[1];
      SPWM_TEC_CH2: event_sel = companion.ch_compare[2];
      SPWM_TEC_ANY: event_sel = |companion.ch_compare;
      SPWM_TEC_PM: event_sel = companion.period_match;
      SPWM_TEC_ZM_UP: event_sel = companion.zero_match && !companion.count_down;
      SPWM_TEC_HALL: event_sel = companion.hall_change;
    endcase
    unique case (spwm_ted_type'(ctrl[`SPWM_CTRL_TED_MSB:`SPWM_CTRL_TED_LSB]))
      SPWM_TED_RSVD: dir_ok = 1'b0;
      SPWM_TED_UP: dir_ok = !companion.count_down;
      SPWM_TED_DOWN: dir_ok = companion.count_down;
      SPWM_TED_BOTH: dir_ok = 1'b1;
    endcase
  end
  assign hw_start = event_sel && dir_ok;

  // ----------------------------------------------------------------------------
  // Run flag
  // ----------------------------------------------------------------------------
  // Sets win over clears so a start is never lost in a collision. Software is
  // trusted not to start with a zero active period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_flag <= 1'b0;
    end else if (run_set_bit || hw_start) begin
      run_flag <= 1'b1;
    end else if (run_clear_bit) begin
      run_flag <= 1'b0;
    end else if (run_flag && tick && period_match && ctrl[`SPWM_CTRL_SSHOT]) begin
      run_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_counter <= `SPWM_RST_COUNT;
    end else if (counter_clear_bit) begin
      pwm_counter <= 16'h0000;
    end else if (!run_flag && wr_en && paddr == `SPWM_OFF_COUNT) begin
      pwm_counter <= pwdata[15:0];
    end else if (run_flag && tick) begin
      if (period_match) begin
        pwm_counter <= 16'h0000;
      end else begin
        pwm_counter <= 16'(pwm_counter + 16'h0001);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Channel state bit
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_state_bit <= 1'b0;
    end else if (state_set_bit) begin
      channel_state_bit <= 1'b1;
    end else if (state_clear_bit) begin
      channel_state_bit <= 1'b0;
    end else if (run_flag && tick) begin
      if (compare_match) begin
        channel_state_bit <= 1'b1;
      end else if (zero_match) begin
        channel_state_bit <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------------
  // Period match and compare strobes are one pclk wide, taken on the count tick that acts on them; zero match is a level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status.period_match <= run_flag && tick && period_match;
      status.zero_match <= zero_match;
      status.channel_compare_event <= run_flag && tick && compare_match;
      status.shadow_xfer_signal <= tick && shadow_xfer_signal;
      status.channel_state_bit <= channel_state_bit;
      status.run_flag <= run_flag;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  sequence s_wrap;
    run_flag && tick && period_match && !counter_clear_bit;
  endsequence
  property p_wrap_zero;
    @(posedge pclk) disable iff (!presetn)
      s_wrap |=> (pwm_counter == 16'h0000);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not wrap");
  property p_count_up;
    @(posedge pclk) disable iff (!presetn)
      (run_flag && tick && !period_match && !counter_clear_bit) |=>
        (pwm_counter == 16'($past(pwm_counter) + 16'h0001));
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step up");
  property p_hold_stopped;
    @(posedge pclk) disable iff (!presetn)
      (!run_flag && !counter_clear_bit && !(wr_en && paddr == `SPWM_OFF_COUNT)) |=>
        $stable(pwm_counter);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("stopped counter moved");
  // Run set and clear bits, a hardware start and a single shot stop may move the run flag beside a clear; all are excluded here.
  property p_clear_keeps_run;
    @(posedge pclk) disable iff (!presetn)
      (counter_clear_bit && !run_set_bit && !run_clear_bit && !hw_start &&
       !(run_flag && tick && period_match && ctrl[`SPWM_CTRL_SSHOT])) |=>
        (pwm_counter == 16'h0000) && (run_flag == $past(run_flag));
  endproperty
  a_clear_keeps_run: assert property (p_clear_keeps_run) else $error("clear hit run");
  property p_sshot;
    @(posedge pclk) disable iff (!presetn)
      (s_wrap and (ctrl[`SPWM_CTRL_SSHOT] && !run_set_bit && !hw_start)) |=> !run_flag;
  endproperty
  a_sshot: assert property (p_sshot) else $error("single shot did not stop");
  property p_hw_start;
    @(posedge pclk) disable iff (!presetn)
      hw_start |=> run_flag;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("trigger did not start");
  property p_both_bits;
    @(posedge pclk) disable iff (!presetn)
      (wr_cmd && pwdata[`SPWM_CMD_RUN_SET] && pwdata[`SPWM_CMD_RUN_CLR] && !hw_start &&
       !(run_flag && tick && period_match)) |=> $stable(run_flag);
  endproperty
  a_both_bits: assert property (p_both_bits) else $error("set and clear changed run");
  property p_period_load;
    @(posedge pclk) disable iff (!presetn)
      !(tick && shadow_xfer_signal) |=> $stable(active_period);
  endproperty
  a_period_load: assert property (p_period_load) else $error("period loaded early");
  property p_state_set;
    @(posedge pclk) disable iff (!presetn)
      (run_flag && tick && compare_match && !state_clear_bit) |=> channel_state_bit;
  endproperty
  a_state_set: assert property (p_state_set) else $error("state bit not set");
  property p_state_clr;
    @(posedge pclk) disable iff (!presetn)
      (run_flag && tick && zero_match && !compare_match && !state_set_bit) |=>
        !channel_state_bit;
  endproperty
  a_state_clr: assert property (p_state_clr) else $error("state bit not cleared");
  property p_state_hold;
    @(posedge pclk) disable iff (!presetn)
      (!run_flag && !wr_mod) |=> $stable(channel_state_bit);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved while stopped");

endmodule

//--- rtl/spwm_cfg.svh
// Register offsets, field positions, reset values and timing counts of the PWM timer.
`ifndef SPWM_CFG_SVH
`define SPWM_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SPWM_OFF_CTRL 12'h000
`define SPWM_OFF_CMD 12'h004
`define SPWM_OFF_COUNT 12'h008
`define SPWM_OFF_PERIOD 12'h00C
`define SPWM_OFF_COMPARE 12'h010
`define SPWM_OFF_STATUS 12'h014
`define SPWM_OFF_MODIFY 12'h018

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SPWM_CTRL_PRESC_LSB 0
`define SPWM_CTRL_PRESC_MSB 3
`define SPWM_CTRL_DIV256 4
`define SPWM_CTRL_EXTSEL 5
`define SPWM_CTRL_SSHOT 6
`define SPWM_CTRL_TEC_LSB 8
`define SPWM_CTRL_TEC_MSB 10
`define SPWM_CTRL_TED_LSB 12
`define SPWM_CTRL_TED_MSB 13

// ----------------------------------------------------------------------------
// Command register fields (write-only, read as zero)
// ----------------------------------------------------------------------------
`define SPWM_CMD_RUN_CLR 0
`define SPWM_CMD_RUN_SET 1
`define SPWM_CMD_CNT_CLR 2
`define SPWM_CMD_SHD_SET 6
`define SPWM_CMD_SHD_CLR 7

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define SPWM_STAT_RUN 0
`define SPWM_STAT_SHD_EN 1
`define SPWM_STAT_CH_STATE 2
`define SPWM_STAT_CMP_EVT 3

// ----------------------------------------------------------------------------
// Compare modify register fields
// ----------------------------------------------------------------------------
`define SPWM_MOD_STATE_SET 0
`define SPWM_MOD_STATE_CLR 1

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define SPWM_RST_COUNT 16'h0000
`define SPWM_RST_CTRL 32'h0000_0000
`define SPWM_DIV256_COUNT 256

`endif

//--- rtl/spwm_pkg.sv
// Types shared by the single channel PWM timer.
package spwm_pkg;

  // Events of the companion timer, sampled at pclk.
  typedef struct packed {
    logic [2:0] ch_compare;
    logic period_match;
    logic zero_match;
    logic count_down;
    logic hall_change;
  } spwm_companion_type;

  // Trigger event selector encodings.
  typedef enum logic [2:0] {
    SPWM_TEC_NONE = 3'h0,
    SPWM_TEC_CH0 = 3'h1,
    SPWM_TEC_CH1 = 3'h2,
    SPWM_TEC_CH2 = 3'h3,
    SPWM_TEC_ANY = 3'h4,
    SPWM_TEC_PM = 3'h5,
    SPWM_TEC_ZM_UP = 3'h6,
    SPWM_TEC_HALL = 3'h7
  } spwm_tec_type;

  // Direction qualifier encodings.
  typedef enum logic [1:0] {
    SPWM_TED_RSVD = 2'h0,
    SPWM_TED_UP = 2'h1,
    SPWM_TED_DOWN = 2'h2,
    SPWM_TED_BOTH = 2'h3
  } spwm_ted_type;

  // Timer outputs that travel together.
  typedef struct packed {
    logic period_match;
    logic zero_match;
    logic channel_compare_event;
    logic shadow_xfer_signal;
    logic channel_state_bit;
    logic run_flag;
  } spwm_status_type;

endpackage

//--- verif/spwm_companion_model.sv
// Companion timer model that drives trigger events into the PWM timer.
`timescale 1ns/100ps
module spwm_companion_model (
  // Clock.
  input wire logic pclk,
  // Bench requests.
  input wire logic fire,
  input wire logic down,
  // Events to the timer.
  output spwm_pkg::spwm_companion_type companion
);
  import spwm_pkg::*;

  // Registered, so each request reaches channel 0 one pclk later and as wide as fire is held.
  // A level held longer would keep re-setting the run flag.
  always_ff @(posedge pclk) begin
    companion <= {2'h0, fire, 1'h0, 1'h0, down, 1'h0};
  end
endmodule

//--- verif/test_single_channel_pwm_timer.sv
// Self-checking bench of the PWM timer.
`timescale 1ns/100ps
`include "spwm_cfg.svh"
module test_single_channel_pwm_timer;
  import spwm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, fire, down, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  spwm_companion_type companion;
  spwm_status_type status;
  int bad_count, cmp_count, pm, cm;

  spwm_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .companion(companion), .external_count_input(1'h0),
    .status(status));
  spwm_companion_model i_comp (.pclk(pclk), .fire(fire), .down(down),
    .companion(companion));

  // Free-running 40 MHz clock.
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Waits a bounded time for the run flag, counting match pulses.
  task automatic wait_run(input logic v, input int lim);
    pm = 0;
    cm = 0;
    for (int i = 0; i < lim && status.run_flag !== v; i++) begin
      @(posedge pclk);
      pm += int'(status.period_match === 1'h1);
      cm += int'(status.channel_compare_event === 1'h1);
    end
  endtask

  // Pclk edges from one period match strobe to the next, bounded.
  task automatic gap(output int n);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (status.period_match !== 1'h1 && n < 99);
    end
  endtask

  task automatic t_regs();
    apb(1'h0, `SPWM_OFF_CTRL, 32'h0);
    check("ctrl reset", `SPWM_RST_CTRL, rd);
    apb(1'h0, 12'h01C, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    apb(1'h1, `SPWM_OFF_PERIOD, 32'h3);
    apb(1'h1, `SPWM_OFF_COMPARE, 32'h1);
    apb(1'h0, `SPWM_OFF_PERIOD, 32'h0);
    check("period", 32'h3, rd);
    apb(1'h0, `SPWM_OFF_COMPARE, 32'h0);
    check("compare", 32'h1, rd);
    apb(1'h1, `SPWM_OFF_COUNT, 32'h5);
    apb(1'h0, `SPWM_OFF_COUNT, 32'h0);
    check("count write", 32'h5, rd);
    apb(1'h1, `SPWM_OFF_CMD, 32'h3);
    apb(1'h1, `SPWM_OFF_CMD, 32'h4);
    apb(1'h0, `SPWM_OFF_COUNT, 32'h0);
    check("count clear", 32'h0, rd);
    check("run set and clear", 32'h0, {31'h0, status.run_flag});
  endtask

  // Nonzero period is in place before any start.
  task automatic t_single();
    apb(1'h1, `SPWM_OFF_CTRL, 32'h40);
    apb(1'h1, `SPWM_OFF_CMD, 32'h2);
    wait_run(1'h1, 5);
    check("run set", 32'h1, {31'h0, status.run_flag});
    wait_run(1'h0, 40);
    check("single shot stop", 32'h0, {31'h0, status.run_flag});
    check("period matches", 32'h1, pm);
    check("compare events", 32'h1, cm);
  endtask

  // Fires a channel 0 event with a given direction and expected start.
  task automatic t_trig(input logic [31:0] ctrl, input logic dn, input logic exp);
    apb(1'h1, `SPWM_OFF_CTRL, ctrl);
    @(posedge pclk);
    {fire, down} <= {1'h1, dn};
    @(posedge pclk);
    fire <= 1'h0;
    repeat (3) @(posedge pclk);
    check("triggered run", {31'h0, exp}, {31'h0, status.run_flag});
    wait_run(1'h0, 40);
  endtask

  // Free running with prescaler, state bit by software, running shadow transfer.
  task automatic t_cont();
    int n;
    apb(1'h1, `SPWM_OFF_MODIFY, 32'h2);
    apb(1'h0, `SPWM_OFF_STATUS, 32'h0);
    check("status stopped", 32'h0, rd);
    apb(1'h1, `SPWM_OFF_MODIFY, 32'h1);
    repeat (2) @(posedge pclk);
    check("state set", 32'h1, {31'h0, status.channel_state_bit});
    check("zero match", 32'h1, {31'h0, status.zero_match});
    apb(1'h1, `SPWM_OFF_CTRL, 32'h1);
    apb(1'h1, `SPWM_OFF_PERIOD, 32'h5);
    apb(1'h1, `SPWM_OFF_CMD, 32'h2);
    gap(n);
    check("period pclks", 32'd12, n);
    apb(1'h1, `SPWM_OFF_COUNT, 32'h100);
    apb(1'h0, `SPWM_OFF_COUNT, 32'h0);
    check("running count write", 32'h1, {31'h0, rd < 32'h6});
    apb(1'h1, `SPWM_OFF_PERIOD, 32'h2);
    apb(1'h0, `SPWM_OFF_PERIOD, 32'h0);
    check("period held", 32'h5, rd);
    apb(1'h1, `SPWM_OFF_CMD, 32'h40);
    for (int i = 0; i < 40 && status.shadow_xfer_signal !== 1'h1; i++) begin
      @(posedge pclk);
    end
    check("shadow transfer", 32'h1, {31'h0, status.shadow_xfer_signal});
    apb(1'h0, `SPWM_OFF_STATUS, 32'h0);
    check("enable cleared", 32'h1, rd & 32'h3);
    gap(n);
    check("new period pclks", 32'd6, n);
    apb(1'h1, `SPWM_OFF_CMD, 32'h1);
    wait_run(1'h0, 5);
    check("run clear", 32'h0, {31'h0, status.run_flag});
  endtask

  // Reset, then the scenarios in order.
  initial begin
    {presetn, psel, penable, pwrite, fire, down} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_single();
    t_trig(32'h1140, 1'h1, 1'h0);
    t_trig(32'h1140, 1'h0, 1'h1);
    t_trig(32'h0140, 1'h0, 1'h0);
    t_cont();
    end_of_test();
  end
endmodule
